// *** vhp_pkg.sv ***
// Shared constants and types of the host port link
package vhp_pkg;
    // Command byte layout
    localparam logic [1:0] DEVSEL_ID     = 2'h1;
    localparam int         CMD_RW_BIT    = 5;
    localparam int         CMD_FR_BIT    = 4;
    // Upper address values for register accesses
    localparam logic [3:0] UA_GENERAL    = 4'h1;
    localparam logic [3:0] UA_NLR1       = 4'h2;
    localparam logic [3:0] UA_NLR2       = 4'h3;
    // Selectors for FIFO accesses
    localparam logic [3:0] FS_STAT0      = 4'h0;
    localparam logic [3:0] FS_STAT1      = 4'h1;
    localparam logic [3:0] FS_VBI        = 4'h4;
    localparam logic [3:0] FS_PRAM       = 4'h5;
    // General register 0x17f releases the processor
    localparam logic [7:0] RELEASE_ADDR  = 8'h7f;
    // Status word layout and constant
    localparam int         STAT0_DREQ_BIT = 4;
    localparam int         STAT0_IRQ_BIT  = 0;
    localparam logic [7:0] STAT1_VALUE    = 8'h37;
    // VBI reads: two wait answers before each byte
    localparam logic [1:0] VBI_WAIT_CNT  = 2'h2;
    // Program RAM address width
    localparam int         PRAM_AW       = 10;
    // Fill interval after a phase one read
    localparam int         SYS_PERIOD_NS = 5;
    localparam int         FILL_US       = 64;
    localparam int         FILL_CYCLES_DEF = FILL_US * 1000 / SYS_PERIOD_NS;
    localparam int         FILL_W        = 14;
    // Link clock divider: half period in system cycles
    localparam logic [4:0] LINK_HALF     = 5'h0a;
    localparam logic [4:0] LINK_DIV_MAX  = 5'h13;
    // Link phase and answer codes
    typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DATA} vhp_phase_t;
    typedef enum logic [1:0] {RS_NONE, RS_ACK, RS_WAIT, RS_TERM} vhp_resp_t;
    // Access kinds decoded from a command byte
    typedef enum logic [3:0] {M_NONE, M_BAD, M_NLR1, M_NLR2, M_STAT0,
                              M_STAT1, M_VBI, M_PRAM, M_GWR, M_REL} vhp_mode_t;
endpackage

// *** vhp_link_if.sv ***
// Host port link between the host controller and the device
`timescale 1ns/10ps
`default_nettype none
interface vhp_link_if;
    import vhp_pkg::*;
    logic       host_port_clock;
    vhp_phase_t phase;
    logic [7:0] h_data;
    logic       h_data_oe;
    logic [7:0] d_data;
    logic       d_data_oe;
    vhp_resp_t  resp;
    logic [7:0] data_bus;
    // Shared data lines resolved from the two enables
    assign data_bus = d_data_oe ? d_data : (h_data_oe ? h_data : 8'h00);
    modport host (output host_port_clock, phase, h_data, h_data_oe,
                  input d_data_oe, resp, data_bus);
    modport dev  (input host_port_clock, phase, h_data_oe, data_bus,
                  output d_data, d_data_oe, resp);
endinterface
`default_nettype wire

// *** vhp_sync.sv ***
// Two flip-flop synchroniser for signals from another domain
`timescale 1ns/10ps
`default_nettype none
module vhp_sync #(
    parameter int W = 1
)(
    // Clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_nrst,
    // Data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } vhp_sync_st_t;
    vhp_sync_st_t st_q;
    vhp_sync_st_t st_d;
    // First stage feeds only the second
    always_comb
    begin
        st_d.meta   = i_d;
        st_d.stable = st_q.meta;
    end
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            st_q <= '0;
        else
            st_q <= st_d;
    end
    assign o_q = st_q.stable;
endmodule
`default_nettype wire

// *** vhp_dev.sv ***
// Device end of the host port: decode, answers, FIFOs, processor hold
`timescale 1ns/10ps
`default_nettype none
module vhp_dev #(
    parameter int FILL_CYCLES = vhp_pkg::FILL_CYCLES_DEF
)(
    // Clock and reset
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_nrst,
    // Link to the host controller
    vhp_link_if.dev                         link,
    // Register file fetch for no-latency reads
    output logic                            o_reg_rd,
    output logic [7:0]                      o_reg_addr,
    input  wire logic [7:0]                 i_reg_rdata,
    // Status sources
    input  wire logic                       i_teletext_thresh,
    input  wire logic                       i_irq_level,
    // Sliced VBI source
    input  wire logic                       i_vbi_valid,
    input  wire logic [7:0]                 i_vbi_data,
    output logic                            o_vbi_pop,
    // Program RAM and processor
    output logic                            o_pram_we,
    output logic [vhp_pkg::PRAM_AW-1:0]     o_pram_addr,
    output logic [7:0]                      o_pram_wdata,
    output logic                            o_cpu_hold
);
    import vhp_pkg::*;

    typedef struct packed {
        logic               clk_seen;
        vhp_mode_t          mode;
        logic [7:0]         ibuf;
        logic [FILL_W-1:0]  fill;
        logic [1:0]         vwait;
        logic [PRAM_AW-1:0] paddr;
        logic [7:0]         d_data;
        logic               d_oe;
        vhp_resp_t          resp;
        logic               reg_rd;
        logic [7:0]         reg_addr;
        logic               vbi_pop;
        logic               pram_we;
        logic [PRAM_AW-1:0] pram_addr;
        logic [7:0]         pram_wdata;
        logic               cpu_hold;
    } vhp_dev_st_t;

    vhp_dev_st_t st_q;
    vhp_dev_st_t st_d;
    logic [10:0] sync_w;
    logic        s_clk;
    vhp_phase_t  s_phase;
    logic [7:0]  s_bus;
    logic        rise;
    logic        busy;

    // Link clock, phase and data all share one synchroniser delay
    vhp_sync #(
        .W (11)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_d       ({link.host_port_clock, link.phase, link.data_bus}),
        .o_q       (sync_w)
    );

    assign s_clk   = sync_w[10];
    assign s_phase = vhp_phase_t'(sync_w[9:8]);
    assign s_bus   = sync_w[7:0];
    assign rise    = s_clk & ~st_q.clk_seen;
    assign busy    = (st_q.fill != '0);

    // Command byte to access kind
    function automatic vhp_mode_t decode(input logic [7:0] cmd);
        vhp_mode_t m;
        m = M_BAD;
        if (cmd[7:6] != DEVSEL_ID)
            m = M_NONE;
        else if (cmd[CMD_FR_BIT])
        begin
            if (cmd[CMD_RW_BIT])
            begin
                if (cmd[3:0] == FS_STAT0)
                    m = M_STAT0;
                else if (cmd[3:0] == FS_STAT1)
                    m = M_STAT1;
                else if (cmd[3:0] == FS_VBI)
                    m = M_VBI;
            end
            else if (cmd[3:0] == FS_PRAM)
                m = M_PRAM;
        end
        else if (cmd[CMD_RW_BIT])
        begin
            if (cmd[3:0] == UA_NLR1)
                m = M_NLR1;
            else if (cmd[3:0] == UA_NLR2)
                m = M_NLR2;
        end
        else if (cmd[3:0] == UA_GENERAL)
            m = M_GWR;
        return m;
    endfunction

    // Next state: one link step per link rising edge, fill countdown every cycle
    always_comb
    begin
        st_d          = st_q;
        st_d.clk_seen = s_clk;
        st_d.reg_rd   = 1'b0;
        st_d.vbi_pop  = 1'b0;
        st_d.pram_we  = 1'b0;
        // Fill countdown; buffer takes the fetched value as it ends
        if (busy)
        begin
            st_d.fill = st_q.fill - 1'b1;
            if (st_q.fill == FILL_W'(1))
                st_d.ibuf = i_reg_rdata;
        end
        if (rise)
        begin
            st_d.resp = RS_NONE;
            st_d.d_oe = 1'b0;
            if (s_phase != PH_IDLE && busy)
            begin
                // Buffer still filling: refuse the access
                st_d.resp = RS_TERM;
                st_d.mode = M_NONE;
            end
            else
            begin
                unique case (s_phase)
                    PH_IDLE:
                    begin
                        st_d.resp = RS_NONE;
                    end
                    PH_CMD:
                    begin
                        st_d.mode  = decode(s_bus);
                        st_d.vwait = VBI_WAIT_CNT;
                        // A fresh download starts at location zero
                        if (st_d.mode == M_PRAM)
                            st_d.paddr = '0;
                        if (st_d.mode != M_NONE)
                            st_d.resp = RS_ACK;
                    end
                    PH_ADDR:
                    begin
                        if (st_q.mode == M_NLR1)
                        begin
                            st_d.reg_addr = s_bus;
                            st_d.reg_rd   = 1'b1;
                        end
                        if (st_q.mode == M_GWR && s_bus == RELEASE_ADDR)
                            st_d.mode = M_REL;
                        if (st_q.mode != M_NONE)
                            st_d.resp = RS_ACK;
                    end
                    PH_DATA:
                    begin
                        st_d.resp = RS_ACK;
                        unique case (st_q.mode)
                            M_NONE:
                                st_d.resp = RS_NONE;
                            M_NLR1:
                            begin
                                // Old buffer now, new value after fill
                                st_d.d_data = st_q.ibuf;
                                st_d.d_oe   = 1'b1;
                                st_d.fill   = FILL_W'(FILL_CYCLES);
                            end
                            M_NLR2:
                            begin
                                st_d.d_data = st_q.ibuf;
                                st_d.d_oe   = 1'b1;
                            end
                            M_STAT0:
                            begin
                                // Undefined bits read as zero
                                st_d.d_data = 8'h00;
                                st_d.d_data[STAT0_DREQ_BIT] =
                                    i_teletext_thresh;
                                st_d.d_data[STAT0_IRQ_BIT] =
                                    i_irq_level;
                                st_d.d_oe   = 1'b1;
                            end
                            M_STAT1:
                            begin
                                st_d.d_data = STAT1_VALUE;
                                st_d.d_oe   = 1'b1;
                            end
                            M_VBI:
                            begin
                                if (st_q.vwait != 2'h0)
                                begin
                                    st_d.resp  = RS_WAIT;
                                    st_d.vwait = st_q.vwait - 1'b1;
                                end
                                else if (i_vbi_valid)
                                begin
                                    st_d.d_data  = i_vbi_data;
                                    st_d.d_oe    = 1'b1;
                                    st_d.vbi_pop = 1'b1;
                                    st_d.vwait   = VBI_WAIT_CNT;
                                end
                                else
                                    // Empty: host polls again later
                                    st_d.resp = RS_TERM;
                            end
                            M_PRAM:
                            begin
                                st_d.pram_we    = 1'b1;
                                st_d.pram_addr  = st_q.paddr;
                                st_d.pram_wdata = s_bus;
                                st_d.paddr      = st_q.paddr + 1'b1;
                                st_d.cpu_hold   = 1'b1;
                            end
                            M_GWR:
                                st_d.resp = RS_ACK;
                            M_REL:
                                st_d.cpu_hold = 1'b0;
                            default:
                                st_d.resp = RS_TERM;
                        endcase
                    end
                endcase
            end
        end
    end

    // Processor held from reset until released by software
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q          <= '0;
            st_q.mode     <= M_NONE;
            st_q.resp     <= RS_NONE;
            st_q.cpu_hold <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    // Outputs straight from the state register
    assign link.d_data    = st_q.d_data;
    assign link.d_data_oe = st_q.d_oe;
    assign link.resp      = st_q.resp;
    assign o_reg_rd       = st_q.reg_rd;
    assign o_reg_addr     = st_q.reg_addr;
    assign o_vbi_pop      = st_q.vbi_pop;
    assign o_pram_we      = st_q.pram_we;
    assign o_pram_addr    = st_q.pram_addr;
    assign o_pram_wdata   = st_q.pram_wdata;
    assign o_cpu_hold     = st_q.cpu_hold;
endmodule
`default_nettype wire

// *** vhp_host.sv ***
// Host controller end: link clock, phase sequencing, answers
`timescale 1ns/10ps
`default_nettype none
module vhp_host #(
    parameter int FILL_CYCLES = vhp_pkg::FILL_CYCLES_DEF
)(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    // Link to the device
    vhp_link_if.host         link,
    // Request
    input  wire logic        i_req_valid,
    input  wire logic [7:0]  i_req_cmd,
    input  wire logic [7:0]  i_req_addr,
    input  wire logic [7:0]  i_req_wdata,
    input  wire logic        i_req_cont,
    output logic             o_req_ready,
    // Answer
    output logic             o_rsp_valid,
    output logic [7:0]       o_rsp_data,
    output logic             o_rsp_term
);
    import vhp_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_PEND, H_CMD, H_ADDR, H_DATA} vhp_hst_t;
    typedef struct packed {
        logic [4:0]        div;
        logic              lclk;
        vhp_hst_t          st;
        logic [7:0]        cmd;
        logic [7:0]        addr;
        logic [7:0]        wdata;
        logic              cont;
        logic [FILL_W-1:0] gap;
        vhp_phase_t        phase;
        logic [7:0]        h_data;
        logic              h_oe;
        logic              ready;
        logic              rsp_valid;
        logic [7:0]        rsp_data;
        logic              rsp_term;
    } vhp_host_st_t;

    vhp_host_st_t st_q;
    vhp_host_st_t st_d;
    logic [9:0]   sync_w;
    vhp_resp_t    s_resp;
    logic [7:0]   s_bus;
    logic         is_nlr1;

    vhp_sync #(
        .W (10)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_d       ({link.resp, link.data_bus}),
        .o_q       (sync_w)
    );

    assign s_resp  = vhp_resp_t'(sync_w[9:8]);
    assign s_bus   = sync_w[7:0];
    assign is_nlr1 = !st_q.cmd[CMD_FR_BIT] && st_q.cmd[CMD_RW_BIT]
                     && st_q.cmd[3:0] == UA_NLR1;

    // Divider makes the link clock; all phase decisions at its falling edge
    always_comb
    begin
        st_d           = st_q;
        st_d.rsp_valid = 1'b0;
        st_d.div  = (st_q.div == LINK_DIV_MAX) ? 5'h00 : st_q.div + 1'b1;
        st_d.lclk = (st_d.div < LINK_HALF);
        if (st_q.gap != '0)
            st_d.gap = st_q.gap - 1'b1;
        if (st_q.ready && i_req_valid)
        begin
            st_d.st    = H_PEND;
            st_d.cmd   = i_req_cmd;
            st_d.addr  = i_req_addr;
            st_d.wdata = i_req_wdata;
            st_d.cont  = i_req_cont;
        end
        if (st_q.div == LINK_HALF - 5'h01)
        begin
            unique case (st_q.st)
                H_IDLE:
                    // A request taken on this very cycle stays pending
                    st_d.rsp_valid = 1'b0;
                H_PEND:
                    // Continued download skips the command phase
                    st_d.st = st_q.cont ? H_DATA : H_CMD;
                H_CMD, H_ADDR, H_DATA:
                begin
                    if (s_resp == RS_TERM || s_resp == RS_NONE)
                    begin
                        st_d.st        = H_IDLE;
                        st_d.rsp_valid = 1'b1;
                        st_d.rsp_term  = 1'b1;
                    end
                    else if (s_resp == RS_ACK)
                    begin
                        if (st_q.st == H_CMD && !st_q.cmd[CMD_FR_BIT])
                            st_d.st = H_ADDR;
                        else if (st_q.st != H_DATA)
                            st_d.st = H_DATA;
                        else
                        begin
                            st_d.st        = H_IDLE;
                            st_d.rsp_valid = 1'b1;
                            st_d.rsp_term  = 1'b0;
                            st_d.rsp_data  = s_bus;
                            // Leave the device room to fill its buffer
                            if (is_nlr1)
                                st_d.gap = FILL_W'(FILL_CYCLES);
                        end
                    end
                end
                default:
                    st_d.st = H_IDLE;
            endcase
        end
        // Link pins follow the phase being presented
        st_d.phase = (st_d.st == H_CMD)  ? PH_CMD :
                     (st_d.st == H_ADDR) ? PH_ADDR :
                     (st_d.st == H_DATA) ? PH_DATA : PH_IDLE;
        st_d.h_data = (st_d.st == H_CMD)  ? st_d.cmd :
                      (st_d.st == H_ADDR) ? st_d.addr : st_d.wdata;
        st_d.h_oe = (st_d.st == H_CMD) || (st_d.st == H_ADDR)
                    || (st_d.st == H_DATA && !st_d.cmd[CMD_RW_BIT]);
        st_d.ready = (st_d.st == H_IDLE) && (st_d.gap == '0);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q       <= '0;
            st_q.st    <= H_IDLE;
            st_q.phase <= PH_IDLE;
        end
        else
            st_q <= st_d;
    end

    assign link.host_port_clock = st_q.lclk;
    assign link.phase           = st_q.phase;
    assign link.h_data          = st_q.h_data;
    assign link.h_data_oe       = st_q.h_oe;
    assign o_req_ready          = st_q.ready;
    assign o_rsp_valid          = st_q.rsp_valid;
    assign o_rsp_data           = st_q.rsp_data;
    assign o_rsp_term           = st_q.rsp_term;
endmodule
`default_nettype wire

// *** vhp_link_props.sv ***
// Assertions on the host port link signals
`timescale 1ns/10ps
`default_nettype none
module vhp_link_props
    import vhp_pkg::*;
(
    // Clock and reset
    input wire logic       i_sys_clk,
    input wire logic       i_nrst,
    // Link signals
    input wire vhp_phase_t phase,
    input wire logic [7:0] h_data,
    input wire logic       h_data_oe,
    input wire logic [7:0] d_data,
    input wire logic       d_data_oe,
    input wire vhp_resp_t  resp
);
    logic [7:0] cmd_q;
    wire        nlr = cmd_q[7:1] == 7'h31;
    // Command of the transfer in flight, so data phases know their kind
    always_ff @(posedge i_sys_clk or negedge i_nrst)
        if (!i_nrst)
            cmd_q <= 8'h00;
        else if (phase == PH_CMD)
            cmd_q <= h_data;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    a_cmd_devsel: assert property (
        phase == PH_CMD |-> h_data_oe && h_data[7:6] == DEVSEL_ID)
        else $error("command byte malformed");
    a_drive_on_read: assert property (
        $rose(d_data_oe) |-> cmd_q[5])
        else $error("device drove data on a write");
    a_nlr_zero_wait: assert property (
        phase != PH_IDLE && nlr |-> resp != RS_WAIT)
        else $error("wait state on no-latency read");
    a_fifo_no_addr: assert property (
        phase == PH_ADDR |-> !cmd_q[4])
        else $error("address phase on FIFO access");
    a_stat0_bits: assert property (
        phase == PH_DATA && cmd_q == 8'h70 && d_data_oe
        |-> d_data[7:5] == 3'h0 && d_data[3:1] == 3'h0)
        else $error("status0 spare bits set");
    a_stat1_const: assert property (
        phase == PH_DATA && cmd_q == 8'h71 && d_data_oe
        |-> d_data == STAT1_VALUE)
        else $error("status1 not constant");
    a_write_quiet: assert property (
        phase == PH_DATA && !cmd_q[5] |-> !d_data_oe)
        else $error("device drove write data phase");
    a_vbi_two_waits: assert property (
        phase == PH_DATA && cmd_q == 8'h74 && $rose(resp == RS_ACK)
        |-> $past(resp, 21) == RS_WAIT && $past(resp, 41) == RS_ACK)
        else $error("VBI byte not after two waits");
endmodule
`default_nettype wire

// *** testbench.sv ***
// Bench joining host and device ends through the link
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import vhp_pkg::*;
    logic       i_sys_clk, i_nrst, i_req_valid, i_req_cont;
    logic [7:0] i_req_cmd, i_req_addr, i_req_wdata, got, vbi_idx = 8'h00;
    logic       i_teletext_thresh, i_irq_level, term, i_vbi_valid;
    logic       o_req_ready, o_rsp_valid, o_rsp_term, o_reg_rd;
    logic       o_vbi_pop, o_pram_we, o_cpu_hold;
    logic [7:0] o_rsp_data, o_reg_addr, o_pram_wdata, pram [0:1023];
    logic [9:0] o_pram_addr;
    int         bad_count, tests_run;
    // Register stand-in loads only on a fetch; VBI source counts up
    logic [7:0] i_reg_rdata = 8'h00;
    wire  [7:0] i_vbi_data = 8'hc0 + vbi_idx;
    vhp_link_if link ();
    vhp_host #(.FILL_CYCLES(40)) i_vhp_host (.i_sys_clk, .i_nrst, .link,
        .i_req_valid, .i_req_cmd, .i_req_addr, .i_req_wdata, .i_req_cont,
        .o_req_ready, .o_rsp_valid, .o_rsp_data, .o_rsp_term);
    vhp_dev #(.FILL_CYCLES(40)) i_vhp_dev (.i_sys_clk, .i_nrst, .link,
        .o_reg_rd, .o_reg_addr, .i_reg_rdata, .i_teletext_thresh,
        .i_irq_level, .i_vbi_valid, .i_vbi_data, .o_vbi_pop,
        .o_pram_we, .o_pram_addr, .o_pram_wdata, .o_cpu_hold);
    vhp_link_props i_props (.i_sys_clk, .i_nrst, .phase(link.phase),
        .h_data(link.h_data), .h_data_oe(link.h_data_oe),
        .d_data(link.d_data), .d_data_oe(link.d_data_oe),
        .resp(link.resp));
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    // One host request; waits are bounded so a hang ends the run
    task automatic xfer(input logic [7:0] c, a, w, input logic k);
        int n;
        n = 0;
        while (o_req_ready !== 1'b1 && n < 500)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        i_req_cmd = c;
        i_req_addr = a;
        i_req_wdata = w;
        i_req_cont = k;
        i_req_valid = 1'b1;
        @(negedge i_sys_clk);
        i_req_valid = 1'b0;
        while (o_rsp_valid !== 1'b1 && n < 1000)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        got = o_rsp_data;
        term = o_rsp_term;
        if (o_rsp_valid !== 1'b1)
        begin
            bad_count++;
            finish_test();
        end
    endtask
    initial
    begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    // Program RAM image, and the hold must stand during every write
    always @(negedge i_sys_clk)
    begin
        if (o_vbi_pop === 1'b1)
            vbi_idx <= vbi_idx + 8'h01;
        if (o_reg_rd === 1'b1)
            i_reg_rdata <= o_reg_addr ^ 8'h5a;
        if (o_pram_we === 1'b1)
        begin
            pram[o_pram_addr] = o_pram_wdata;
            chk1(o_cpu_hold, 1'b1);
        end
    end
    initial
    begin
        {i_nrst, i_req_valid, i_req_cont, i_teletext_thresh} = 4'h0;
        {i_req_cmd, i_req_addr, i_req_wdata} = 24'h000000;
        i_irq_level = 1'b1;
        i_vbi_valid = 1'b1;
        bad_count = 0;
        tests_run = 0;
        repeat (3) @(negedge i_sys_clk);
        i_nrst = 1'b1;
        @(negedge i_sys_clk);
        chk1(o_cpu_hold, 1'b1);
        xfer(8'h70, 8'h00, 8'h00, 1'b0);
        chk8(got, 8'h01);
        i_irq_level = 1'b0;
        i_teletext_thresh = 1'b1;
        xfer(8'h70, 8'h00, 8'h00, 1'b0);
        chk8(got, 8'h10);
        xfer(8'h71, 8'h00, 8'h00, 1'b0);
        chk8(got, STAT1_VALUE);
        xfer(8'h76, 8'h00, 8'h00, 1'b0);
        chk1(term, 1'b1);
        $display("test status words done");
        xfer(8'h62, 8'h33, 8'h00, 1'b0);
        chk1(term, 1'b0);
        chk1(o_req_ready, 1'b0);
        xfer(8'h62, 8'h44, 8'h00, 1'b0);
        chk8(got, 8'h33 ^ 8'h5a);
        xfer(8'h63, 8'h00, 8'h00, 1'b0);
        chk8(got, 8'h44 ^ 8'h5a);
        xfer(8'h63, 8'hff, 8'h00, 1'b0);
        chk8(got, 8'h44 ^ 8'h5a);
        $display("test no-latency reads done");
        i_vbi_valid = 1'b0;
        xfer(8'h74, 8'h00, 8'h00, 1'b0);
        chk1(term, 1'b1);
        i_vbi_valid = 1'b1;
        xfer(8'h74, 8'h00, 8'h00, 1'b0);
        chk8(got, 8'hc0);
        xfer(8'h74, 8'h00, 8'h00, 1'b0);
        chk8(got, 8'hc1);
        $display("test VBI polling done");
        xfer(8'h55, 8'h00, 8'ha1, 1'b0);
        xfer(8'h55, 8'h00, 8'hb2, 1'b1);
        xfer(8'h55, 8'h00, 8'hc3, 1'b1);
        chk8(pram[0], 8'ha1);
        chk8(pram[1], 8'hb2);
        chk8(pram[2], 8'hc3);
        xfer(8'h41, 8'h7e, 8'h00, 1'b0);
        chk1(o_cpu_hold, 1'b1);
        xfer(8'h41, RELEASE_ADDR, 8'h9c, 1'b0);
        chk1(o_cpu_hold, 1'b0);
        xfer(8'h55, 8'h00, 8'hd4, 1'b0);
        chk1(o_cpu_hold, 1'b1);
        chk8(pram[0], 8'hd4);
        xfer(8'h41, RELEASE_ADDR, 8'h00, 1'b0);
        chk1(o_cpu_hold, 1'b0);
        $display("test download and release done");
        finish_test();
    end
endmodule
`default_nettype wire
